// ### mpc_pkg.sv
/*
  mpc_pkg: shared constants and types for the mode pin control block.
  assumes: one 20 MHz clock; no register bus, all controls are pins.
*/
package mpc_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned ADDR_BASE_W   = 7;
  localparam logic [6:0]  ADDR_BASE     = 7'h48;  // arbitrary base, lsb strap
  localparam int unsigned SILENCE_HALF  = 8;      // cycles per half period
  localparam logic [3:0]  SILENCE_MAX   = 4'h7;
  localparam int unsigned NUM_PINS      = 12;

  typedef enum logic [1:0] {
    MPC_RATE_18M = 2'b00,
    MPC_RATE_24M = 2'b01,
    MPC_RATE_27M = 2'b10,
    MPC_RATE_RSV = 2'b11
  } mpc_rate_t;

  typedef enum logic [1:0] {
    MPC_ST_RESET = 2'b00,
    MPC_ST_LATCH = 2'b01,
    MPC_ST_RUN   = 2'b10
  } mpc_state_t;
endpackage : mpc_pkg

// ### mpc_sync_if.sv
/*
  mpc_sync_if: carries raw pin levels into the synchroniser and the
  settled levels back out. assumes one clock domain on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
interface mpc_sync_if;
  import mpc_pkg::*;
  logic [NUM_PINS-1:0] raw;
  logic [NUM_PINS-1:0] sync;
  modport core (output raw, input sync);
  modport sync_side (input raw, output sync);
endinterface : mpc_sync_if
`default_nettype wire

// ### mpc_sync.sv
/*
  mpc_sync: two-flop synchroniser for every asynchronous pin.
  assumes pins settle between edges often enough for level use.
*/
`timescale 1ns/1ps
`default_nettype none
module mpc_sync
  import mpc_pkg::*;
(
  input  wire logic  clk,  // system clock
  input  wire logic  rst,  // async reset, high
  mpc_sync_if.sync_side  s  // raw in, settled out
);
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_bit
      // per-bit flops keep each process the only writer of its state
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= s.raw[g];
          sync_r <= meta_r;
        end
      end
      assign s.sync[g] = sync_r;
    end
  endgenerate
endmodule : mpc_sync
`default_nettype wire

// ### mpc_silence.sv
/*
  mpc_silence: free-running square wave with equal high and low time,
  used as the muted pwm pattern. assumes a single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mpc_silence
  import mpc_pkg::*;
(
  input  wire logic  clk,      // system clock
  input  wire logic  rst,      // async reset, high
  input  wire logic  run,      // count only when enabled
  output logic       square    // 50% duty pattern
);
  logic [3:0] cnt_r;
  logic       sq_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (!run || cnt_r == SILENCE_MAX) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // toggling on a fixed count keeps high and low time equal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sq_r <= 1'b0;
    end else if (!run) begin
      sq_r <= 1'b0;
    end else if (cnt_r == SILENCE_MAX) begin
      sq_r <= ~sq_r;
    end
  end

  assign square = sq_r;
endmodule : mpc_silence
`default_nettype wire

// ### mpc_top.sv
/*
  mpc_top: pin-level mode control and flag logic of the amplifier.
  assumes all pins are asynchronous to CLK; processing lives elsewhere.
*/
// Functional notes
// - reset low holds low power, defaults
// - latch address strap at reset release
// - software mode interrupt output on condition
// - source pin high picks converter, else serial
// - mute low forces 50% square on pwm
// - foldback enabled only while pin high
// - format pin high i2s, low left-justified
// - two rate pins give clock frequency
// - combined thermal/undervoltage error output
// - overcurrent error output
// - thermal warning output pin
// - headphone pin is detect or mute
// - delay pin is data or warning
`timescale 1ns/1ps
`default_nettype none
module mpc_top
  import mpc_pkg::*;
(
  input  wire logic       CLK,                     // 20 MHz system clock
  input  wire logic       RST,                     // async reset, high
  input  wire logic       RESET_N_PIN,             // reset pin, low
  input  wire logic       HW_MODE,                 // 1 hardware, 0 software
  input  wire logic       AUX_FRAME_OR_ADDR_STRAP, // strap level
  input  wire logic       INPUT_SOURCE_SELECT,     // converter/serial
  input  wire logic       MUTE_N,                  // hardware mute, low
  input  wire logic       FOLDBACK_ENABLE_PIN,     // foldback enable
  input  wire logic       SERIAL_FORMAT_SELECT,    // serial_format_select
  input  wire logic       CLOCK_RATE_SELECT_0,     // rate select bit 0
  input  wire logic       CLOCK_RATE_SELECT_1,     // rate select bit 1
  input  wire logic       HEADPHONE_SENSE_INPUT,   // shared sense pin
  input  wire logic       DELAY_IN_OR_EXT_WARN,    // shared delay pin
  input  wire logic       SW_SENSE_IS_MUTE,        // sense pin role
  input  wire logic       SW_DELAY_IS_WARN,        // delay pin role
  input  wire logic       SW_IRQ_PENDING,          // interrupt condition
  input  wire logic       COND_THERMAL_ERR,        // thermal shutdown
  input  wire logic       COND_UNDERVOLT,          // undervoltage
  input  wire logic       COND_OVERCURRENT,        // overcurrent
  input  wire logic       COND_THERMAL_WARN,       // thermal warning
  input  wire logic [1:0] PWM_DATA,                // pwm from modulator
  output logic            LOW_POWER,               // low power state
  output logic            REG_DEFAULTS,            // registers to default
  output logic [6:0]      TARGET_ADDR,             // bus target address
  output logic            ADDR_VALID,              // address latched
  output logic            USE_CONVERTER,           // audio from converter
  output logic            FMT_I2S,                 // 1 i2s, 0 lj
  output logic            FOLDBACK_ON,             // foldback active
  output logic [1:0]      CLOCK_RATE,              // rate code
  output logic            HP_PRESENT,              // headphone present
  output logic            SENSE_MUTE,              // mute from sense pin
  output logic            DELAY_DATA,              // delay return data
  output logic            EXT_WARN,                // external warning
  output logic [1:0]      PWM_OUT,                 // pwm outputs
  output logic            INT_N_O,                 // interrupt drive level
  output logic            INT_N_OE,                // interrupt enable
  output logic            THERMAL_UV_ERROR_N_O,    // error drive level
  output logic            THERMAL_UV_ERROR_N_OE,   // error enable
  output logic            OVERCURRENT_ERROR_N_O,   // oc drive level
  output logic            OVERCURRENT_ERROR_N_OE,  // oc enable
  output logic            THERMAL_WARN_OUT_O,      // warn drive level
  output logic            THERMAL_WARN_OUT_OE      // warn enable
);
  localparam int P_RSTN = 0;
  localparam int P_STRAP = 1;
  localparam int P_SRC = 2;
  localparam int P_MUTE = 3;
  localparam int P_FB = 4;
  localparam int P_FMT = 5;
  localparam int P_R0 = 6;
  localparam int P_R1 = 7;
  localparam int P_HP = 8;
  localparam int P_DLY = 9;
  localparam int P_MODE = 10;
  localparam int P_SPARE = 11;

  mpc_sync_if sif ();
  mpc_state_t state_r;
  mpc_state_t state_nxt;
  logic       strap_r;
  logic       hw;
  logic       square;
  logic [NUM_PINS-1:0] p;

  assign sif.raw = {1'b0, HW_MODE, DELAY_IN_OR_EXT_WARN,
                    HEADPHONE_SENSE_INPUT, CLOCK_RATE_SELECT_1,
                    CLOCK_RATE_SELECT_0, SERIAL_FORMAT_SELECT,
                    FOLDBACK_ENABLE_PIN, MUTE_N,
                    INPUT_SOURCE_SELECT, AUX_FRAME_OR_ADDR_STRAP,
                    RESET_N_PIN};
  assign p  = sif.sync;
  assign hw = p[P_MODE];

  mpc_sync u_sync (
    .clk (CLK),
    .rst (RST),
    .s   (sif.sync_side)
  );

  // square keeps running only in the run state so it starts clean
  mpc_silence u_sil (
    .clk    (CLK),
    .rst    (RST),
    .run    (state_r == MPC_ST_RUN),
    .square (square)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MPC_ST_RESET: if (p[P_RSTN]) state_nxt = MPC_ST_LATCH;
      MPC_ST_LATCH: state_nxt = p[P_RSTN] ? MPC_ST_RUN : MPC_ST_RESET;
      MPC_ST_RUN:   if (!p[P_RSTN]) state_nxt = MPC_ST_RESET;
      default:      state_nxt = MPC_ST_RESET;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= MPC_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // strap is sampled once, in the cycle the reset pin is seen released
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      strap_r <= 1'b0;
    end else if (state_r == MPC_ST_RESET) begin
      // a held reset pin clears the strap; release latches the new level
      strap_r <= p[P_RSTN] ? p[P_STRAP] : 1'b0;
    end
  end

  assign LOW_POWER    = (state_r == MPC_ST_RESET);
  assign REG_DEFAULTS = (state_r == MPC_ST_RESET);
  assign TARGET_ADDR  = {ADDR_BASE[6:1], strap_r};
  assign ADDR_VALID   = (state_r == MPC_ST_RUN);

  // configuration outputs are registered so they change cleanly
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      USE_CONVERTER <= 1'b0;
      FMT_I2S       <= 1'b0;
      FOLDBACK_ON   <= 1'b0;
      CLOCK_RATE    <= 2'b00;
    end else if (state_r != MPC_ST_RUN) begin
      USE_CONVERTER <= 1'b0;
      FMT_I2S       <= 1'b0;
      FOLDBACK_ON   <= 1'b0;
      CLOCK_RATE    <= 2'b00;
    end else if (hw) begin
      USE_CONVERTER <= p[P_SRC];
      FMT_I2S       <= p[P_FMT];
      FOLDBACK_ON   <= p[P_FB];
      CLOCK_RATE    <= {p[P_R1], p[P_R0]};
    end
  end

  // shared software-mode pins; role chosen by control bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HP_PRESENT <= 1'b0;
      SENSE_MUTE <= 1'b0;
      DELAY_DATA <= 1'b0;
      EXT_WARN   <= 1'b0;
    end else if (state_r != MPC_ST_RUN || hw) begin
      HP_PRESENT <= 1'b0;
      SENSE_MUTE <= 1'b0;
      DELAY_DATA <= 1'b0;
      EXT_WARN   <= 1'b0;
    end else begin
      HP_PRESENT <= !SW_SENSE_IS_MUTE && p[P_HP];
      SENSE_MUTE <= SW_SENSE_IS_MUTE && p[P_HP];
      DELAY_DATA <= !SW_DELAY_IS_WARN && p[P_DLY];
      EXT_WARN   <= SW_DELAY_IS_WARN && p[P_DLY];
    end
  end

  // silence replaces audio; pwm held low outside run to save power
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PWM_OUT <= 2'b00;
    end else if (state_r != MPC_ST_RUN) begin
      PWM_OUT <= 2'b00;
    end else if (hw && !p[P_MUTE]) begin
      PWM_OUT <= {square, square};
    end else begin
      PWM_OUT <= PWM_DATA;
    end
  end

  // open-drain flags: drive low while active, release otherwise
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      INT_N_OE               <= 1'b0;
      THERMAL_UV_ERROR_N_OE  <= 1'b0;
      OVERCURRENT_ERROR_N_OE <= 1'b0;
      THERMAL_WARN_OUT_OE    <= 1'b0;
    end else if (state_r != MPC_ST_RUN) begin
      INT_N_OE               <= 1'b0;
      THERMAL_UV_ERROR_N_OE  <= 1'b0;
      OVERCURRENT_ERROR_N_OE <= 1'b0;
      THERMAL_WARN_OUT_OE    <= 1'b0;
    end else begin
      INT_N_OE               <= !hw && SW_IRQ_PENDING;
      THERMAL_UV_ERROR_N_OE  <= hw &&
                                (COND_THERMAL_ERR || COND_UNDERVOLT);
      OVERCURRENT_ERROR_N_OE <= hw && COND_OVERCURRENT;
      // warning pin is open drain too, driven high level absent: low=warn
      THERMAL_WARN_OUT_OE    <= hw && COND_THERMAL_WARN;
    end
  end

  assign INT_N_O               = 1'b0;
  assign THERMAL_UV_ERROR_N_O  = 1'b0;
  assign OVERCURRENT_ERROR_N_O = 1'b0;
  assign THERMAL_WARN_OUT_O    = 1'b0;
endmodule : mpc_top
`default_nettype wire

// ### mpc_top_assertions.sv
/*
  mpc_top_assertions: port-level checks of mpc_top.
  assumes the bench holds each pin level for several cycles at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module mpc_top_assertions
  import mpc_pkg::*;
(
  input wire logic       CLK,                    // system clock
  input wire logic       RST,                    // async reset, high
  input wire logic       RESET_N_PIN,            // reset pin
  input wire logic       HW_MODE,                // mode pin
  input wire logic       AUX_FRAME_OR_ADDR_STRAP, // strap pin
  input wire logic       SW_IRQ_PENDING,         // interrupt cause
  input wire logic       COND_THERMAL_ERR,       // thermal shutdown
  input wire logic       COND_UNDERVOLT,         // undervoltage
  input wire logic       COND_OVERCURRENT,       // overcurrent
  input wire logic       COND_THERMAL_WARN,      // thermal warning
  input wire logic       LOW_POWER,              // low power state
  input wire logic       REG_DEFAULTS,           // defaults forced
  input wire logic [6:0] TARGET_ADDR,            // bus address
  input wire logic       ADDR_VALID,             // run state
  input wire logic       INT_N_OE,               // interrupt pulled low
  input wire logic       THERMAL_UV_ERROR_N_OE,  // error pulled low
  input wire logic       OVERCURRENT_ERROR_N_OE, // oc pulled low
  input wire logic       THERMAL_WARN_OUT_OE     // warn pulled low
);
  // a mode or reset pin counts as settled once five samples agree,
  // which covers the two sync flops and the output register
  logic [4:0] hw_h_r;
  logic [4:0] lo_h_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) hw_h_r <= 5'h00;
    else hw_h_r <= {hw_h_r[3:0], HW_MODE};
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) lo_h_r <= 5'h00;
    else lo_h_r <= {lo_h_r[3:0], ~RESET_N_PIN};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_low_power_hold: assert property (&lo_h_r |-> LOW_POWER &&
    REG_DEFAULTS && !ADDR_VALID) else $error("reset pin state wrong");
  // strap is taken two sync edges before entering latch, three before run
  a_addr_base_bits: assert property ($rose(ADDR_VALID) |->
    TARGET_ADDR == {ADDR_BASE[6:1], $past(AUX_FRAME_OR_ADDR_STRAP, 4)})
    else $error("latched address wrong");
  a_addr_held_run: assert property (ADDR_VALID && $past(ADDR_VALID)
    |-> $stable(TARGET_ADDR)) else $error("address moved in run");
  a_int_follows_cause: assert property (ADDR_VALID && $past(ADDR_VALID)
    && ~|hw_h_r |-> INT_N_OE == $past(SW_IRQ_PENDING))
    else $error("interrupt level wrong");
  a_int_quiet_hw: assert property (&hw_h_r |-> !INT_N_OE)
    else $error("interrupt driven in hardware mode");
  a_uv_error_flag: assert property (ADDR_VALID && $past(ADDR_VALID)
    && &hw_h_r |-> THERMAL_UV_ERROR_N_OE ==
    $past(COND_THERMAL_ERR || COND_UNDERVOLT)) else $error("uv flag wrong");
  a_oc_error_flag: assert property (ADDR_VALID && $past(ADDR_VALID)
    && &hw_h_r |-> OVERCURRENT_ERROR_N_OE == $past(COND_OVERCURRENT))
    else $error("oc flag wrong");
  a_warn_out_flag: assert property (ADDR_VALID && $past(ADDR_VALID)
    && &hw_h_r |-> THERMAL_WARN_OUT_OE == $past(COND_THERMAL_WARN))
    else $error("warn flag wrong");
endmodule : mpc_top_assertions
`default_nettype wire

// ### mpc_board.sv
/*
  mpc_board: board straps and a serial audio source for mpc_top.
  assumes the bench hands over wanted strap levels on a vector.
*/
`timescale 1ns/1ps
`default_nettype none
module mpc_board (
  input  wire logic        CLK,            // system clock
  input  wire logic [10:0] want,           // wanted strap levels
  output logic      [10:0] pins = 11'h000, // strap pin levels
  output logic             frame_clock,    // channel select
  output logic             serial_audio_in // sample bits
);
  localparam logic [15:0] SAMPLE = 16'hc000; // a negative word
  logic [5:0] bit_r = 6'h00;
  // straps move on the falling edge, away from the sampling edge
  always @(negedge CLK) pins <= want;
  always @(negedge CLK) bit_r <= bit_r + 6'h01;
  assign frame_clock = bit_r[5];
  assign serial_audio_in = SAMPLE[4'hf - bit_r[3:0]];
endmodule : mpc_board
`default_nettype wire

// ### mpc_top_tb.sv
/*
  mpc_top_tb: self-checking bench for mpc_top.
  assumes mpc_board and mpc_top_assertions are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module mpc_top_tb;
  import mpc_pkg::*;
  logic CLK = 1'b0, RST = 1'b1, SW_SENSE_IS_MUTE = 1'b0;
  logic SW_DELAY_IS_WARN = 1'b0, SW_IRQ_PENDING = 1'b0;
  logic COND_THERMAL_ERR = 1'b0, COND_UNDERVOLT = 1'b0;
  logic COND_OVERCURRENT = 1'b0, COND_THERMAL_WARN = 1'b0;
  logic [1:0] PWM_DATA = 2'b11, CLOCK_RATE, PWM_OUT;
  logic [10:0] w = 11'h000, want = 11'h000;
  wire logic [10:0] pn;
  logic [6:0] TARGET_ADDR, n0, n1;
  logic LOW_POWER, REG_DEFAULTS, ADDR_VALID, USE_CONVERTER, FMT_I2S;
  logic FOLDBACK_ON, HP_PRESENT, SENSE_MUTE, DELAY_DATA, EXT_WARN;
  logic INT_N_O, INT_N_OE, THERMAL_UV_ERROR_N_O, THERMAL_UV_ERROR_N_OE;
  logic OVERCURRENT_ERROR_N_O, OVERCURRENT_ERROR_N_OE;
  logic THERMAL_WARN_OUT_O, THERMAL_WARN_OUT_OE;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #25 CLK = ~CLK;
  mpc_board u_board (.CLK, .want, .pins(pn), .frame_clock(),
    .serial_audio_in());
  mpc_top dut (.CLK, .RST, .RESET_N_PIN(pn[0]), .HW_MODE(pn[1]),
    .AUX_FRAME_OR_ADDR_STRAP(pn[2]), .INPUT_SOURCE_SELECT(pn[3]),
    .MUTE_N(pn[4]), .FOLDBACK_ENABLE_PIN(pn[5]),
    .SERIAL_FORMAT_SELECT(pn[6]), .CLOCK_RATE_SELECT_0(pn[7]),
    .CLOCK_RATE_SELECT_1(pn[8]), .HEADPHONE_SENSE_INPUT(pn[9]),
    .DELAY_IN_OR_EXT_WARN(pn[10]), .SW_SENSE_IS_MUTE, .SW_DELAY_IS_WARN,
    .SW_IRQ_PENDING, .COND_THERMAL_ERR, .COND_UNDERVOLT, .COND_OVERCURRENT,
    .COND_THERMAL_WARN, .PWM_DATA, .LOW_POWER, .REG_DEFAULTS, .TARGET_ADDR,
    .ADDR_VALID, .USE_CONVERTER, .FMT_I2S, .FOLDBACK_ON, .CLOCK_RATE,
    .HP_PRESENT, .SENSE_MUTE, .DELAY_DATA, .EXT_WARN, .PWM_OUT, .INT_N_O,
    .INT_N_OE, .THERMAL_UV_ERROR_N_O, .THERMAL_UV_ERROR_N_OE,
    .OVERCURRENT_ERROR_N_O, .OVERCURRENT_ERROR_N_OE, .THERMAL_WARN_OUT_O,
    .THERMAL_WARN_OUT_OE);
  task automatic chk(string nm, logic [6:0] seen, logic [6:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // board latency plus sync and output register, with two spare edges
  task automatic go();
    want <= w;
    repeat (6) @(negedge CLK);
  endtask : go
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic t_reset(logic s);
    w = 11'h000;
    w[2] = s;
    go();
    chk("low_power", LOW_POWER, 1);
    chk("addr_dflt", TARGET_ADDR, {ADDR_BASE[6:1], 1'b0});
    chk("reg_defaults", REG_DEFAULTS, 1);
    w[0] = 1'b1;
    go();
    chk("addr", TARGET_ADDR, {ADDR_BASE[6:1], s});
    w[2] = ~s;
    go();
    chk("addr_kept", TARGET_ADDR, {ADDR_BASE[6:1], s});
    chk("awake", LOW_POWER, 0);
  endtask : t_reset
  task automatic t_hw_cfg();
    for (int k = 0; k < 32; k++) begin
      // hw mode, unmuted, sense pin high; k walks source/fb/fmt/rate
      w[10:1] = {1'b0, 1'b1, k[4:1], 1'b1, k[0], w[2], 1'b1};
      go();
      chk("source", USE_CONVERTER, k[0]);
      chk("foldback", FOLDBACK_ON, k[1]);
      chk("format", FMT_I2S, k[2]);
      chk("rate", CLOCK_RATE, k[4:3]);
      chk("hp_refused", HP_PRESENT, 0);
    end
  endtask : t_hw_cfg
  task automatic t_flags();
    SW_IRQ_PENDING <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      {COND_THERMAL_WARN, COND_OVERCURRENT, COND_UNDERVOLT,
       COND_THERMAL_ERR} <= k[3:0];
      repeat (3) @(negedge CLK);
      chk("uv_flag", THERMAL_UV_ERROR_N_OE, k[0] | k[1]);
      chk("oc_flag", OVERCURRENT_ERROR_N_OE, k[2]);
      chk("warn_flag", THERMAL_WARN_OUT_OE, k[3]);
      chk("levels", {THERMAL_UV_ERROR_N_O, OVERCURRENT_ERROR_N_O,
        THERMAL_WARN_OUT_O}, 0);
      chk("int_hw", INT_N_OE, 0);
    end
    w[1] = 1'b0;
    go();
    for (int k = 0; k < 2; k++) begin
      SW_IRQ_PENDING <= k[0];
      repeat (3) @(negedge CLK);
      chk("int", INT_N_OE, k[0]);
      chk("int_level", INT_N_O, 0);
      chk("uv_sw", THERMAL_UV_ERROR_N_OE, 0);
    end
  endtask : t_flags
  task automatic t_mute();
    w[1] = 1'b1;
    w[4] = 1'b0;
    go();
    n0 = 7'h00;
    n1 = 7'h00;
    // any 64-cycle span of a 16-cycle square holds exactly 32 high cycles
    repeat (64) begin
      @(negedge CLK);
      n0 = n0 + PWM_OUT[0];
      n1 = n1 + PWM_OUT[1];
    end
    chk("pwm0_high", n0, 7'h20);
    chk("pwm1_high", n1, 7'h20);
    w[4] = 1'b1;
    go();
    chk("pwm_pass", PWM_OUT, 2'b11);
  endtask : t_mute
  task automatic t_shared();
    w[1] = 1'b0;
    for (int k = 0; k < 8; k++) begin
      {SW_DELAY_IS_WARN, SW_SENSE_IS_MUTE} <= k[1:0];
      w[10:9] = {2{k[2]}};
      go();
      chk("hp", HP_PRESENT, k[2] & ~k[0]);
      chk("smute", SENSE_MUTE, k[2] & k[0]);
      chk("dly", DELAY_DATA, k[2] & ~k[1]);
      chk("xwarn", EXT_WARN, k[2] & k[1]);
    end
  endtask : t_shared
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(negedge CLK);
    RST <= 1'b0;
    t_reset(1'b1);
    t_hw_cfg();
    t_flags();
    t_mute();
    t_shared();
    t_reset(1'b0);
    close_out();
  end
endmodule : mpc_top_tb
bind mpc_top mpc_top_assertions u_chk (.CLK, .RST, .RESET_N_PIN, .HW_MODE,
  .AUX_FRAME_OR_ADDR_STRAP,
  .SW_IRQ_PENDING, .COND_THERMAL_ERR, .COND_UNDERVOLT, .COND_OVERCURRENT,
  .COND_THERMAL_WARN, .LOW_POWER, .REG_DEFAULTS, .TARGET_ADDR, .ADDR_VALID,
  .INT_N_OE, .THERMAL_UV_ERROR_N_OE, .OVERCURRENT_ERROR_N_OE,
  .THERMAL_WARN_OUT_OE);
`default_nettype wire
